// File: pkg/timer_rb_pkg.sv
// Purpose: constants for the timer read-back and null-count block
// Assumes: APB slave, 32-bit data, three counters
// Notes: register offsets are byte addresses of aligned words

package timer_rb_pkg;

    // ==========================================================
    // sizes
    localparam int NUM_CTR = 3;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int MODE_W = 6;
    localparam int ADDR_W = 8;

    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CNT0 = 8'h04;
    localparam logic [7:0] ADDR_CNT1 = 8'h08;
    localparam logic [7:0] ADDR_CNT2 = 8'h0c;
    localparam logic [7:0] ADDR_NULL = 8'h10;

    // ==========================================================
    // control word and read-back command fields
    localparam int CW_SEL_HI = 7;
    localparam int CW_SEL_LO = 6;
    localparam int CW_RL_HI = 5;
    localparam int CW_RL_LO = 4;
    localparam int RB_CNT_N = 5;
    localparam int RB_STAT_N = 4;
    localparam int RB_SEL_LO = 1;
    localparam int MODE_RL_HI = 5;
    localparam int MODE_RL_LO = 4;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] RL_LATCH = 2'h0;
    localparam logic [1:0] RL_LSB = 2'h1;
    localparam logic [1:0] RL_MSB = 2'h2;
    localparam logic [1:0] RL_BOTH = 2'h3;

    // ==========================================================
    // reset values
    localparam logic [5:0] MODE_RESET = 6'h30;
    localparam logic NULL_RESET = 1'b1;
    localparam logic [15:0] CR_RESET = 16'h0000;

endpackage

// File: hw/latch_slot.sv
// Purpose: one latch that keeps its first captured value until released
// Assumes: capture and release never arrive in the same cycle
// Notes: a capture while full is ignored

`timescale 1ns/10ps

module latch_slot #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic capture,
    input wire logic release_latch,
    input wire logic [WIDTH-1:0] value_in,
    output logic full,
    output logic [WIDTH-1:0] value
);

    typedef struct packed {
        logic full;
        logic [WIDTH-1:0] value;
    } slot_s;

    slot_s q;
    slot_s d;

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        if (release_latch) begin
            d.full = 1'b0;
        end else if (capture && !q.full) begin
            d.full = 1'b1;
            d.value = value_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign full = q.full;
    assign value = q.value;

endmodule // latch_slot

// File: hw/timer_readback.sv
// Purpose: read-back latching and null-count tracking of a three-counter
//          interval timer, reached over APB
// Assumes: counting elements sit outside and report loads and outputs
// Notes: pready is always high; read data is sampled in the setup cycle
//
// Function
// (R1) programming a counter's control word sets its null-count flag
// (R2) count write sets null-count; two-byte format sets it on second byte
// (R3) transfer of holding count into counting element clears null-count
// (R4) each counter has its own independent null-count flag
// (R5) further status latches ignored while latched status is unread
// (R6) read-back with both latch bits zero latches count and status
// (R7) repeated latch of an unread item is ignored, first value kept
// (R8) with both latched, first read returns the status byte
// (R9) after status, next one or two reads return latched count
// (R10) multi-counter read-back latches each selected counter not already full
// (R11) read-back: bit5 low count, bit4 low status, bits3..1 select counters
// (R12) status byte: output pin bit7, null-count bit6, mode bits 5..0
// (R13) reading every byte of a latch releases it for new latches

`timescale 1ns/10ps

module timer_readback (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0][15:0] ce_count,
    input wire logic [2:0] ce_load,
    input wire logic [2:0] out_pin,
    output logic [2:0][15:0] count_holding_register,
    output logic [2:0] cr_written,
    output logic [2:0][5:0] ctrl_mode,
    output logic [2:0] null_count
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [5:0] mode;
        logic null_flag;
        logic rd_msb;
        logic wr_msb;
        logic [15:0] cr;
    } counter_s;

    typedef struct packed {
        counter_s [2:0] ctr;
        logic [2:0] written;
        logic [7:0] rdata;
    } state_s;

    state_s q;
    state_s d;

    // ==========================================================
    // bus decode
    logic setup;
    logic acc_wr;
    logic acc_rd;
    logic addr_ok;
    logic is_cnt;
    logic [1:0] cnt_idx;
    logic [7:0] wbyte;
    logic [1:0] cw_sel;
    logic [1:0] cw_rl;
    logic readback;
    logic [2:0] rb_sel;

    assign setup = psel && !penable;
    assign acc_wr = psel && penable && pwrite && addr_ok;
    assign acc_rd = psel && penable && !pwrite && addr_ok;
    assign is_cnt = (paddr == timer_rb_pkg::ADDR_CNT0)
                 || (paddr == timer_rb_pkg::ADDR_CNT1)
                 || (paddr == timer_rb_pkg::ADDR_CNT2);
    assign addr_ok = is_cnt || (paddr == timer_rb_pkg::ADDR_CTRL)
                  || (paddr == timer_rb_pkg::ADDR_NULL);
    assign cnt_idx = 2'(paddr[7:2] - 6'h01);
    assign wbyte = pwdata[7:0];
    assign cw_sel = wbyte[timer_rb_pkg::CW_SEL_HI:timer_rb_pkg::CW_SEL_LO];
    assign cw_rl = wbyte[timer_rb_pkg::CW_RL_HI:timer_rb_pkg::CW_RL_LO];
    assign readback = acc_wr && (paddr == timer_rb_pkg::ADDR_CTRL)
                   && (cw_sel == timer_rb_pkg::SEL_READBACK);
    assign rb_sel = wbyte[timer_rb_pkg::RB_SEL_LO +: 3];

    // ==========================================================
    // latch requests and releases per counter
    logic [2:0] cnt_cap;
    logic [2:0] st_cap;
    logic [2:0] cnt_rel;
    logic [2:0] st_rel;
    logic [2:0] cnt_full;
    logic [2:0] st_full;
    logic [2:0][15:0] cnt_val;
    logic [2:0][7:0] st_val;
    logic [2:0][7:0] st_now;
    logic [2:0] prog_wr;
    logic [2:0] cnt_wr;
    logic [2:0] cnt_rd;

    always_comb begin
        for (int i = 0; i < timer_rb_pkg::NUM_CTR; i++) begin
            prog_wr[i] = acc_wr && (paddr == timer_rb_pkg::ADDR_CTRL)
                      && (cw_sel == 2'(i));
            cnt_wr[i] = acc_wr && is_cnt && (cnt_idx == 2'(i));
            cnt_rd[i] = acc_rd && is_cnt && (cnt_idx == 2'(i));
            // (R11) read-back encoding
            // (R6) both latch bits low latch both items
            // (R10) each selected counter asks separately
            cnt_cap[i] = (readback && rb_sel[i]
                         && !wbyte[timer_rb_pkg::RB_CNT_N])
                      || (prog_wr[i] && cw_rl == timer_rb_pkg::RL_LATCH);
            st_cap[i] = readback && rb_sel[i]
                     && !wbyte[timer_rb_pkg::RB_STAT_N];
            // (R12) status byte layout
            st_now[i] = {out_pin[i], q.ctr[i].null_flag, q.ctr[i].mode};
        end
    end

    // (R13) release after the last byte; the count latch is also released on reprogramming
    always_comb begin
        for (int i = 0; i < timer_rb_pkg::NUM_CTR; i++) begin
            st_rel[i] = cnt_rd[i] && st_full[i];
            cnt_rel[i] = (cnt_rd[i] && !st_full[i]
                         && (q.ctr[i].rd_msb
                             || q.ctr[i].mode[timer_rb_pkg::MODE_RL_HI:
                                              timer_rb_pkg::MODE_RL_LO]
                                != timer_rb_pkg::RL_BOTH))
                      || (prog_wr[i] && cw_rl != timer_rb_pkg::RL_LATCH);
        end
    end

    // ==========================================================
    // latch slots
    for (genvar g = 0; g < 3; g++) begin : g_ctr
        // (R7) count latch keeps its first value
        latch_slot #(
            .WIDTH(timer_rb_pkg::CNT_W)
        ) u_count (
            .pclk(pclk),
            .presetn(presetn),
            .capture(cnt_cap[g]),
            .release_latch(cnt_rel[g]),
            .value_in(ce_count[g]),
            .full(cnt_full[g]),
            .value(cnt_val[g])
        );
        // (R5) status latch keeps its first value
        latch_slot #(
            .WIDTH(timer_rb_pkg::BYTE_W)
        ) u_status (
            .pclk(pclk),
            .presetn(presetn),
            .capture(st_cap[g]),
            .release_latch(st_rel[g]),
            .value_in(st_now[g]),
            .full(st_full[g]),
            .value(st_val[g])
        );
    end

    // ==========================================================
    // read data selection
    logic [7:0] rd_byte;
    logic [15:0] rd_cnt;
    logic [1:0] rd_rl;
    logic [7:0] null_bits;

    always_comb begin
        rd_byte = 8'h00;
        rd_cnt = 16'h0000;
        rd_rl = timer_rb_pkg::RL_LSB;
        null_bits = 8'h00;
        for (int i = 0; i < timer_rb_pkg::NUM_CTR; i++) begin
            null_bits[i] = q.ctr[i].null_flag;
        end
        if (is_cnt && cnt_idx < 2'd3) begin
            rd_rl = q.ctr[cnt_idx].mode[timer_rb_pkg::MODE_RL_HI:
                                        timer_rb_pkg::MODE_RL_LO];
            rd_cnt = cnt_full[cnt_idx] ? cnt_val[cnt_idx]
                                       : ce_count[cnt_idx];
            if (st_full[cnt_idx]) begin
                // (R8) status goes out first
                rd_byte = st_val[cnt_idx];
            end else begin
                // (R9) count bytes follow in the programmed format
                unique case (rd_rl)
                    timer_rb_pkg::RL_MSB: rd_byte = rd_cnt[15:8];
                    timer_rb_pkg::RL_BOTH: begin
                        rd_byte = q.ctr[cnt_idx].rd_msb ? rd_cnt[15:8]
                                                        : rd_cnt[7:0];
                    end
                    default: rd_byte = rd_cnt[7:0];
                endcase
            end
        end else if (paddr == timer_rb_pkg::ADDR_NULL) begin
            rd_byte = null_bits;
        end
    end

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        d.written = 3'b000;
        if (setup) begin
            d.rdata = rd_byte;
        end
        for (int i = 0; i < timer_rb_pkg::NUM_CTR; i++) begin
            // (R3) load into counting element clears
            // (R4) each flag moves on its own counter's events only
            if (ce_load[i]) begin
                d.ctr[i].null_flag = 1'b0;
            end
            if (prog_wr[i] && cw_rl != timer_rb_pkg::RL_LATCH) begin
                d.ctr[i].mode = wbyte[5:0];
                d.ctr[i].rd_msb = 1'b0;
                d.ctr[i].wr_msb = 1'b0;
                // (R1) programming sets null-count
                d.ctr[i].null_flag = 1'b1;
            end
            if (cnt_wr[i]) begin
                unique case (q.ctr[i].mode[timer_rb_pkg::MODE_RL_HI:
                                           timer_rb_pkg::MODE_RL_LO])
                    timer_rb_pkg::RL_LSB: begin
                        d.ctr[i].cr = {8'h00, wbyte};
                        d.written[i] = 1'b1;
                    end
                    timer_rb_pkg::RL_MSB: begin
                        d.ctr[i].cr = {wbyte, 8'h00};
                        d.written[i] = 1'b1;
                    end
                    timer_rb_pkg::RL_BOTH: begin
                        d.ctr[i].wr_msb = !q.ctr[i].wr_msb;
                        if (q.ctr[i].wr_msb) begin
                            d.ctr[i].cr[15:8] = wbyte;
                            d.written[i] = 1'b1;
                        end else begin
                            d.ctr[i].cr[7:0] = wbyte;
                        end
                    end
                    default: begin
                        d.written[i] = 1'b0;
                    end
                endcase
                // (R2) complete count write sets null-count
                if (d.written[i]) begin
                    d.ctr[i].null_flag = 1'b1;
                end
            end
            // two-byte reads alternate once the status is out
            if (cnt_rd[i] && !st_full[i]
                && q.ctr[i].mode[timer_rb_pkg::MODE_RL_HI:
                                 timer_rb_pkg::MODE_RL_LO]
                   == timer_rb_pkg::RL_BOTH) begin
                d.ctr[i].rd_msb = !q.ctr[i].rd_msb;
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < timer_rb_pkg::NUM_CTR; i++) begin
                q.ctr[i].mode <= timer_rb_pkg::MODE_RESET;
                q.ctr[i].null_flag <= timer_rb_pkg::NULL_RESET;
                q.ctr[i].rd_msb <= 1'b0;
                q.ctr[i].wr_msb <= 1'b0;
                q.ctr[i].cr <= timer_rb_pkg::CR_RESET;
            end
            q.written <= 3'b000;
            q.rdata <= 8'h00;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    assign prdata = {24'h000000, q.rdata};
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign cr_written = q.written;

    always_comb begin
        for (int i = 0; i < timer_rb_pkg::NUM_CTR; i++) begin
            count_holding_register[i] = q.ctr[i].cr;
            ctrl_mode[i] = q.ctr[i].mode;
            null_count[i] = q.ctr[i].null_flag;
        end
    end

endmodule // timer_readback

// File: tb/timer_readback_checker.sv
// Purpose: port-level assertions for the timer read-back block
// Assumes: single pclk domain, presetn active low
// Notes: bound into every timer_readback instance

`timescale 1ns/10ps

module timer_readback_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0][15:0] ce_count,
    input wire logic [2:0] ce_load,
    input wire logic [2:0] out_pin,
    input wire logic [2:0][15:0] count_holding_register,
    input wire logic [2:0] cr_written,
    input wire logic [2:0][5:0] ctrl_mode,
    input wire logic [2:0] null_count
);
    // ==========================================================
    // helpers
    logic acc;
    logic ctl_w;
    assign acc = psel && penable;
    assign ctl_w = acc && pwrite && paddr == timer_rb_pkg::ADDR_CTRL;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ==========================================================
    // assertions
    chk_ctrl_sets_null: assert property (
        ctl_w && pwdata[7:6] != 2'h3 && pwdata[5:4] != 2'h0
        |=> null_count[$past(pwdata[7:6])]) else $error("null not set");
    chk_latch_no_null: assert property (
        ctl_w && pwdata[7:6] != 2'h3 && pwdata[5:4] == 2'h0
        && ce_load == 3'h0 |=> $stable(null_count))
        else $error("latch changed null");
    chk_count_sets_null: assert property (
        cr_written[0] |-> null_count[0]) else $error("count no null");
    chk_written_cause: assert property (
        cr_written[0] |-> $past(acc && pwrite
        && paddr == timer_rb_pkg::ADDR_CNT0)) else $error("stray write");
    chk_load_clears: assert property (
        ce_load[0] && !(acc && pwrite) |=> !null_count[0])
        else $error("load kept null");
    chk_null_separate: assert property (
        ctl_w && pwdata[7:6] == 2'h0 && ce_load == 3'h0
        |=> $stable(null_count[2:1])) else $error("other null moved");
    chk_null_readout: assert property (
        acc && !pwrite && paddr == timer_rb_pkg::ADDR_NULL
        |-> prdata[2:0] == $past(null_count)) else $error("null read");
    chk_mode_stored: assert property (
        ctl_w && pwdata[7:6] != 2'h3 && pwdata[5:4] != 2'h0
        |=> ctrl_mode[$past(pwdata[7:6])] == $past(pwdata[5:0]))
        else $error("mode not stored");
    chk_readback_mode: assert property (
        ctl_w && pwdata[7:6] == 2'h3 |=> $stable(ctrl_mode))
        else $error("read-back changed mode");
endmodule // timer_readback_checker

bind timer_readback timer_readback_checker timer_readback_checker_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ce_count, .ce_load, .out_pin,
    .count_holding_register, .cr_written, .ctrl_mode, .null_count);

// File: tb/apb_host.sv
// Purpose: host cpu model issuing apb transfers
// Assumes: caller runs in the pclk domain
// Notes: idle address and data show the inverse of the last value

`timescale 1ns/10ps

module apb_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hff;
        pwdata = 32'h0;
    end

    // ==========================================================
    // one transfer, waits for pready at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // apb_host

// File: tb/timer_readback_tb.sv
// Purpose: self-checking bench for the timer read-back block
// Assumes: counters programmed for two-byte counts, counter 2 later reprogrammed for one-byte
// Notes: table rows cover null flags, hand tests cover latching

`timescale 1ns/10ps

module timer_readback_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic er;
    logic [2:0][15:0] ce_count = {16'h5e6f, 16'h3c4d, 16'h1a2b};
    logic [2:0] ce_load = 3'h0;
    logic [2:0] out_pin = 3'h5;
    logic [2:0][15:0] count_holding_register;
    logic [2:0] cr_written, null_count;
    logic [2:0][5:0] ctrl_mode;
    int bad_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    // row: address, data, load mask, expected null flags
    logic [21:0] rows [6] = '{{8'h00, 8'h34, 3'h7, 3'h0},
        {8'h00, 8'h74, 3'h0, 3'h2}, {8'h04, 8'h11, 3'h0, 3'h2},
        {8'h04, 8'h22, 3'h0, 3'h3}, {8'h00, 8'hb4, 3'h1, 3'h6},
        {8'h00, 8'hce, 3'h6, 3'h0}};

    always #5 pclk = ~pclk;

    apb_host apb_host_i (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    timer_readback timer_readback_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ce_count(ce_count), .ce_load(ce_load),
        .out_pin(out_pin), .count_holding_register(count_holding_register),
        .cr_written(cr_written), .ctrl_mode(ctrl_mode),
        .null_count(null_count));

    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] seen, exp, input string nm);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb_host_i.xfer(1'b1, a, {24'h0, d}, v, er);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        apb_host_i.xfer(1'b0, a, 32'h0, v, er);
        chk(v, {24'h0, e}, "prdata");
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            test_done;
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk({26'h0, ctrl_mode[0]}, 32'h30, "mode");
        rdchk(timer_rb_pkg::ADDR_NULL, 8'h07);
        foreach (rows[i]) begin
            wr(rows[i][21:14], rows[i][13:6]);
            @(posedge pclk);
            ce_load <= rows[i][5:3];
            @(posedge pclk);
            ce_load <= 3'h0;
            rdchk(timer_rb_pkg::ADDR_NULL, {5'h0, rows[i][2:0]});
        end
        chk(count_holding_register[0], 16'h2211, "cr0");
        @(posedge pclk);
        ce_count <= {16'h0506, 16'h0304, 16'h0102};
        out_pin <= 3'h2;
        // repeated latches onto full slots, command bits per encoding
        wr(8'h00, 8'hce);
        wr(8'h00, 8'he4);
        rdchk(8'h04, 8'hb4);
        rdchk(8'h04, 8'h2b);
        rdchk(8'h04, 8'h1a);
        rdchk(8'h04, 8'h02);
        rdchk(8'h04, 8'h01);
        rdchk(8'h08, 8'h74);
        rdchk(8'h08, 8'h4d);
        rdchk(8'h08, 8'h3c);
        rdchk(8'h0c, 8'hf4);
        wr(8'h00, 8'hda);
        @(posedge pclk);
        ce_count[0] <= 16'h0708;
        rdchk(8'h0c, 8'h6f);
        rdchk(8'h0c, 8'h5e);
        rdchk(8'h04, 8'h02);
        rdchk(8'h04, 8'h01);
        // count latched before status: status still goes out first
        wr(8'h00, 8'hd4);
        wr(8'h00, 8'he4);
        rdchk(8'h08, 8'hb4);
        rdchk(8'h08, 8'h04);
        rdchk(8'h08, 8'h03);
        // one-byte format, counter latch command, one-byte count write
        wr(8'h00, 8'h90);
        wr(8'h00, 8'h80);
        ce_count[2] <= 16'h0a0b;
        rdchk(8'h0c, 8'h06);
        rdchk(8'h0c, 8'h0b);
        @(posedge pclk);
        ce_load <= 3'h4;
        @(posedge pclk);
        ce_load <= 3'h0;
        wr(8'h0c, 8'h55);
        rdchk(timer_rb_pkg::ADDR_NULL, 8'h04);
        chk(count_holding_register[2], 16'h0055, "cr2");
        apb_host_i.xfer(1'b0, 8'h14, 32'h0, v, er);
        chk({31'h0, er}, 32'h1, "pslverr");
        // reset in mid-run returns every counter to its reset state
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk({26'h0, ctrl_mode[2]}, 32'h30, "mode");
        rdchk(timer_rb_pkg::ADDR_NULL, 8'h07);
        test_done;
    end
endmodule // timer_readback_tb
